// File: logic/asc_pkg.sv
// Constants, field layout, types and states of the serial conversion interface
//----------------------------------------------------------------------------
// What this block does
// - 1x result combines two conversions, offset removed
// - Speed-double disables calibration, doubles output rate
// - First result after change already valid
// - Temperature select forces 1x, ignores speed-double
// - Clock high at select fall selects internal mode
// - Data out released while select is high
// - Select low shows done flag: 1 busy, 0 sleeping
// - Done conversion sleeps, result held in shifter
// - Sleep until first clock rise with select low, in external clock mode only
// - One input bit taken per clock rise, first 16 rises only
// - New settings apply to the following conversion
// - Output changes on falls; host latches on rises
// - 32nd fall starts conversion, data out high
// - Select rise mid-cycle aborts, starts conversion
// - Abort before 8th fall keeps old channel
// - 8 to 15 falls loads channel only
// - Three-wire clock source decided at power-on end
// - Three-wire shows done flag continuously
// - Three-wire loads result when flag falls
// - Three-wire 32nd fall restarts conversion, flag high
// - Enable prefix 101 alone makes channel field valid
// - Update bit loads configuration, which persists
//----------------------------------------------------------------------------
package asc_pkg;

  // Timing
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned POR_TIME_MS = 4;
  localparam int unsigned POR_CYC     = (POR_TIME_MS * CLK_FREQ_HZ + 999) / 1000;

  // Word and counter sizing
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned CNT_W     = 6;
  localparam int unsigned IN_W      = 16;
  localparam int unsigned SMP_W     = 30;

  localparam logic [CNT_W-1:0] FALL_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] FALL_LAST = 6'h1f;
  localparam logic [CNT_W-1:0] FALL_CHAN = 6'h08;
  localparam logic [CNT_W-1:0] FALL_CFG  = 6'h10;
  localparam logic [CNT_W-1:0] RISE_ONE  = 6'h01;
  localparam logic [CNT_W-1:0] RISE_FULL = 6'h10;

  // Input word layout, first bit received at the top
  localparam int unsigned PRE_HI  = 15;
  localparam int unsigned PRE_LO  = 13;
  localparam int unsigned CH_HI   = 12;
  localparam int unsigned CH_LO   = 8;
  localparam int unsigned EN2_POS = 7;
  localparam int unsigned IM_POS  = 6;
  localparam int unsigned FA_POS  = 5;
  localparam int unsigned FB_POS  = 4;
  localparam int unsigned SPD_POS = 3;
  localparam logic [2:0]  PRE_APPLY = 3'h5;

  // Output word head: done flag low, then a zero bit
  localparam logic [1:0] OUT_HEAD = 2'h0;

  typedef struct packed {
    logic [4:0] chan;
    logic       temp_sensor_select;
    logic       rejection_select_a;
    logic       rejection_select_b;
    logic       speed_double_select;
  } asc_cfg_t;

  localparam asc_cfg_t CFG_RST = '{chan: 5'h00, temp_sensor_select: 1'b0,
                                   rejection_select_a: 1'b0, rejection_select_b: 1'b0,
                                   speed_double_select: 1'b0};

  typedef enum logic [1:0] {
    ST_POR   = 2'b00,
    ST_CONV  = 2'b01,
    ST_SLEEP = 2'b10,
    ST_IO    = 2'b11
  } asc_state_t;

endpackage : asc_pkg

// File: logic/asc_smp_buf.sv
// Small valid/ready buffer for converter samples
`timescale 1ns/1ns
module asc_smp_buf #(
  parameter int unsigned W     = 30,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // Filling side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Draining side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("asc_smp_buf: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0]  mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0]   cnt_reg;
  logic [PW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push     = i_in_valid & o_in_ready;
  assign pop      = o_out_valid & i_out_ready;
  assign cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);

  // Storage, written by index
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and occupancy; full/empty flags kept as registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      cnt_reg     <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)  rd_ptr_reg <= rd_ptr_reg + PW'(1);
      cnt_reg     <= cnt_next;
      o_in_ready  <= (cnt_next != (PW+1)'(DEPTH));
      o_out_valid <= (cnt_next != '0);
    end
  end

  assign o_out_data = mem_reg[rd_ptr_reg];

endmodule : asc_smp_buf

// File: logic/asc_serial_if.sv
// Serial control and data interface of a multi-channel delta-sigma converter
`timescale 1ns/1ns
module asc_serial_if #(
  parameter int unsigned P_POR_CYCLES = asc_pkg::POR_CYC,
  parameter int unsigned P_BUF_DEPTH  = 2
) (
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst,
  // Serial pins
  input  wire logic                        i_sck,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_sdi,
  output logic                             o_sdo,
  output logic                             o_sdo_oe,
  // Sample stream from the modulator
  input  wire logic                        i_smp_valid,
  input  wire logic [asc_pkg::SMP_W-1:0]   i_smp_data,
  output logic                             o_smp_ready,
  // Modulator control
  output logic                             o_conv_busy,
  output logic                             o_conv_swap,
  output asc_pkg::asc_cfg_t                o_conv_cfg,
  // Status
  output logic                             o_por_done,
  output logic                             o_int_clk_mode,
  output asc_pkg::asc_cfg_t                o_cfg
);

  localparam int unsigned PORW = $clog2(P_POR_CYCLES + 1);

  generate
    if (P_POR_CYCLES < 1) begin : g_bad_por
      $error("asc_serial_if: P_POR_CYCLES must be at least 1");
    end
  endgenerate

  //--------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  //--------------------------------------------------------------------------
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic sdi_s1_reg, sdi_s2_reg;
  logic sck_rise, sck_fall, cs_rise, cs_fall, cs_low;

  // Two stages per pin, a third on clock and select for edges; only the second and later stages feed logic
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= i_sck;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      cs_s1_reg  <= i_cs_n;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      sdi_s1_reg <= i_sdi;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  assign sck_rise = sck_s2_reg & ~sck_s3_reg;
  assign sck_fall = ~sck_s2_reg & sck_s3_reg;
  assign cs_rise  = cs_s2_reg & ~cs_s3_reg;
  assign cs_fall  = ~cs_s2_reg & cs_s3_reg;
  assign cs_low   = ~cs_s2_reg;

  //--------------------------------------------------------------------------
  // Sample buffer between modulator and result engine
  //--------------------------------------------------------------------------
  logic                      smp_valid;
  logic [asc_pkg::SMP_W-1:0] smp_data;
  logic                      smp_take;
  asc_pkg::asc_state_t       state_reg;
  asc_pkg::asc_state_t       state_next;

  // Only a running conversion drains; otherwise the buffer fills and stalls
  assign smp_take = (state_reg == asc_pkg::ST_CONV);

  asc_smp_buf #(
    .W     (asc_pkg::SMP_W),
    .DEPTH (P_BUF_DEPTH)
  ) u_buf (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_smp_valid),
    .i_in_data   (i_smp_data),
    .o_in_ready  (o_smp_ready),
    .o_out_valid (smp_valid),
    .o_out_data  (smp_data),
    .i_out_ready (smp_take)
  );

  //--------------------------------------------------------------------------
  // Cycle events
  //--------------------------------------------------------------------------
  logic [PORW-1:0]            por_cnt_reg;
  logic [asc_pkg::CNT_W-1:0]  rise_cnt_reg;
  logic [asc_pkg::CNT_W-1:0]  fall_cnt_reg;
  logic [asc_pkg::IN_W-1:0]   in_word_reg;
  logic [asc_pkg::WORD_BITS-1:0] out_sr_reg;
  logic [asc_pkg::WORD_BITS-1:0] out_sr_next;
  logic                       phase_reg;
  logic [asc_pkg::SMP_W-1:0]  first_smp_reg;
  logic                       por_end, io_start, last_fall, abort, quit;
  logic                       start_conv, conv_done, speed_eff;
  logic                       load_chan, load_cfg;
  asc_pkg::asc_cfg_t          cfg_next;

  assign por_end   = (state_reg == asc_pkg::ST_POR) &&
                     (por_cnt_reg == PORW'(P_POR_CYCLES - 1));
  assign io_start  = (state_reg == asc_pkg::ST_SLEEP) && cs_low && sck_rise
                     && !o_int_clk_mode;
  assign last_fall = (state_reg == asc_pkg::ST_IO) && cs_low && sck_fall
                     && (fall_cnt_reg == asc_pkg::FALL_LAST);
  assign abort     = (state_reg == asc_pkg::ST_IO) && cs_rise
                     && (fall_cnt_reg != asc_pkg::FALL_ZERO);
  assign quit      = (state_reg == asc_pkg::ST_IO) && cs_rise
                     && (fall_cnt_reg == asc_pkg::FALL_ZERO);
  assign start_conv = por_end || last_fall || abort;

  // Temperature conversions always run the offset-cancelling 1x scheme
  assign speed_eff = o_conv_cfg.speed_double_select
                     & ~o_conv_cfg.temp_sensor_select;
  assign conv_done = (state_reg == asc_pkg::ST_CONV) && smp_valid
                     && (phase_reg || speed_eff);

  //--------------------------------------------------------------------------
  // Settings decode: which fields arrived before the cycle ended
  //--------------------------------------------------------------------------
  always_comb begin
    load_chan = (last_fall || (abort && fall_cnt_reg >= asc_pkg::FALL_CHAN))
                && (in_word_reg[asc_pkg::PRE_HI:asc_pkg::PRE_LO] == asc_pkg::PRE_APPLY);
    load_cfg  = load_chan && in_word_reg[asc_pkg::EN2_POS]
                && (last_fall || fall_cnt_reg >= asc_pkg::FALL_CFG);
    cfg_next  = o_cfg;
    if (load_chan) begin
      cfg_next.chan = in_word_reg[asc_pkg::CH_HI:asc_pkg::CH_LO];
    end
    if (load_cfg) begin
      cfg_next.temp_sensor_select  = in_word_reg[asc_pkg::IM_POS];
      cfg_next.rejection_select_a  = in_word_reg[asc_pkg::FA_POS];
      cfg_next.rejection_select_b  = in_word_reg[asc_pkg::FB_POS];
      cfg_next.speed_double_select = in_word_reg[asc_pkg::SPD_POS];
    end
  end

  // Current settings persist until a later word replaces them
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cfg <= asc_pkg::CFG_RST;
    end else begin
      o_cfg <= cfg_next;
    end
  end

  //--------------------------------------------------------------------------
  // Power-on period and clock source selection
  //--------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      por_cnt_reg    <= '0;
      o_por_done     <= 1'b0;
      o_int_clk_mode <= 1'b0;
    end else begin
      if (state_reg == asc_pkg::ST_POR) begin
        por_cnt_reg <= por_cnt_reg + PORW'(1);
      end
      if (por_end) begin
        o_por_done     <= 1'b1;
        o_int_clk_mode <= sck_s2_reg;
      end else if (o_por_done && cs_fall) begin
        o_int_clk_mode <= sck_s2_reg;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      asc_pkg::ST_POR:   if (por_end) state_next = asc_pkg::ST_CONV;
      asc_pkg::ST_CONV:  if (conv_done) state_next = asc_pkg::ST_SLEEP;
      asc_pkg::ST_SLEEP: if (io_start) state_next = asc_pkg::ST_IO;
      asc_pkg::ST_IO: begin
        if (last_fall || abort) begin
          state_next = asc_pkg::ST_CONV;
        end else if (quit) begin
          state_next = asc_pkg::ST_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= asc_pkg::ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  //--------------------------------------------------------------------------
  // Bit counters and input word capture
  //--------------------------------------------------------------------------
  // Falls counted from zero at every select fall and cycle start
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rise_cnt_reg <= '0;
      fall_cnt_reg <= '0;
      in_word_reg  <= '0;
    end else if (cs_fall) begin
      rise_cnt_reg <= '0;
      fall_cnt_reg <= '0;
    end else if (io_start) begin
      rise_cnt_reg <= asc_pkg::RISE_ONE;
      fall_cnt_reg <= '0;
      in_word_reg  <= '0;
      in_word_reg[asc_pkg::IN_W-1] <= sdi_s2_reg;
    end else if (state_reg == asc_pkg::ST_IO) begin
      // Bits past the sixteenth carry nothing and are dropped
      if (sck_rise && rise_cnt_reg < asc_pkg::RISE_FULL) begin
        in_word_reg[4'(asc_pkg::IN_W - 1) - rise_cnt_reg[3:0]] <= sdi_s2_reg;
        rise_cnt_reg <= rise_cnt_reg + asc_pkg::RISE_ONE;
      end
      if (sck_fall) begin
        fall_cnt_reg <= fall_cnt_reg + asc_pkg::RISE_ONE;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Result engine
  //--------------------------------------------------------------------------
  logic signed [asc_pkg::SMP_W:0]   diff;
  logic        [asc_pkg::SMP_W-1:0] result;

  // Normal and swapped passes subtracted so offset cancels out
  assign diff   = $signed({first_smp_reg[asc_pkg::SMP_W-1], first_smp_reg})
                  - $signed({smp_data[asc_pkg::SMP_W-1], smp_data});
  assign result = speed_eff ? smp_data : diff[asc_pkg::SMP_W:1];

  // Each conversion uses only its own samples, so no settling latency
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      phase_reg     <= 1'b0;
      first_smp_reg <= '0;
      o_conv_busy   <= 1'b0;
      o_conv_swap   <= 1'b0;
      o_conv_cfg    <= asc_pkg::CFG_RST;
    end else if (start_conv) begin
      phase_reg   <= 1'b0;
      o_conv_busy <= 1'b1;
      o_conv_swap <= 1'b0;
      o_conv_cfg  <= cfg_next;
    end else if (conv_done) begin
      o_conv_busy <= 1'b0;
      o_conv_swap <= 1'b0;
    end else if (state_reg == asc_pkg::ST_CONV && smp_valid) begin
      first_smp_reg <= smp_data;
      phase_reg     <= 1'b1;
      o_conv_swap   <= 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // Output shifter and data pin
  //--------------------------------------------------------------------------
  always_comb begin
    out_sr_next = out_sr_reg;
    if (conv_done) begin
      out_sr_next = {asc_pkg::OUT_HEAD, result};
    end else if (state_reg == asc_pkg::ST_IO && sck_fall) begin
      out_sr_next = {out_sr_reg[asc_pkg::WORD_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      out_sr_reg <= '0;
    end else begin
      out_sr_reg <= out_sr_next;
    end
  end

  // Pin level follows state: busy high, asleep low, data while shifting
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sdo    <= 1'b1;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo_oe <= cs_low;
      unique case (state_next)
        asc_pkg::ST_POR:   o_sdo <= 1'b1;
        asc_pkg::ST_CONV:  o_sdo <= 1'b1;
        asc_pkg::ST_SLEEP: o_sdo <= 1'b0;
        asc_pkg::ST_IO:    o_sdo <= out_sr_next[asc_pkg::WORD_BITS-1];
      endcase
    end
  end

endmodule : asc_serial_if

// File: sim/asc_serial_if_checker.sv
// Port-level checks of the serial conversion interface
`timescale 1ns/1ns
module asc_serial_if_checker #(
  parameter int unsigned P_POR_CYCLES = asc_pkg::POR_CYC,
  parameter int unsigned P_BUF_DEPTH  = 2
) (
  // Clock and reset
  input wire logic                      i_sys_clk,
  input wire logic                      i_rst,
  // Serial pins
  input wire logic                      i_sck,
  input wire logic                      i_cs_n,
  input wire logic                      i_sdi,
  input wire logic                      o_sdo,
  input wire logic                      o_sdo_oe,
  // Sample stream
  input wire logic                      i_smp_valid,
  input wire logic [asc_pkg::SMP_W-1:0] i_smp_data,
  input wire logic                      o_smp_ready,
  // Conversion and status
  input wire logic                      o_conv_busy,
  input wire logic                      o_conv_swap,
  input wire asc_pkg::asc_cfg_t         o_conv_cfg,
  input wire logic                      o_por_done,
  input wire logic                      o_int_clk_mode,
  input wire asc_pkg::asc_cfg_t         o_cfg
);
  //--------------------------------------------------------------------------
  // Helper logic and checks
  //--------------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [31:0] por_cnt;

  // Cycles since reset release; saturates so it never wraps
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      por_cnt <= 32'h0;
    end else if (por_cnt < P_POR_CYCLES + 3) begin
      por_cnt <= por_cnt + 32'h1;
    end
  end

  // Select falls with the clock pin steady at lvl, then both hold
  sequence s_cs_fall(lvl);
    o_por_done && $fell(i_cs_n) && (i_sck == lvl) ##1 (!i_cs_n && (i_sck == lvl))[*4];
  endsequence

  a_sdo_release: assert property (i_cs_n[*4] |-> !o_sdo_oe)
    else $error("data pin driven while select high");
  a_sdo_drive: assert property ((!i_cs_n)[*4] |-> o_sdo_oe)
    else $error("data pin not driven while select low");
  a_flag_busy: assert property (o_sdo_oe && o_conv_busy |-> o_sdo)
    else $error("done flag low during conversion");
  a_flag_sleep: assert property ($fell(o_conv_busy) && o_sdo_oe |-> ##[0:1] !o_sdo)
    else $error("done flag not low after conversion");
  a_cfg_frozen: assert property (o_conv_busy && $past(o_conv_busy) |-> $stable(o_conv_cfg))
    else $error("settings changed during conversion");
  a_swap_mode: assert property ($rose(o_conv_swap) |-> o_conv_busy &&
      !(o_conv_cfg.speed_double_select && !o_conv_cfg.temp_sensor_select))
    else $error("second pass outside a 1x conversion");
  a_pass_count: assert property ($fell(o_conv_busy) |-> $past(o_conv_swap) ==
      ($past(o_conv_cfg.temp_sensor_select) || !$past(o_conv_cfg.speed_double_select)))
    else $error("pass count does not match speed mode");
  a_int_mode_set: assert property (s_cs_fall(1'h1) |-> o_int_clk_mode)
    else $error("internal clock mode not chosen");
  a_ext_mode_set: assert property (s_cs_fall(1'h0) |-> !o_int_clk_mode)
    else $error("external clock mode not kept");
  a_por_wait: assert property (!o_por_done |-> !o_conv_busy)
    else $error("conversion before power-on period ends");
  a_por_length: assert property (por_cnt == P_POR_CYCLES + 2 |->
      o_por_done && !$past(o_por_done, 3))
    else $error("power-on period length wrong");
endmodule : asc_serial_if_checker

bind asc_serial_if asc_serial_if_checker #(
  .P_POR_CYCLES(P_POR_CYCLES), .P_BUF_DEPTH(P_BUF_DEPTH)
) asc_serial_if_checker_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_sdi(i_sdi),
  .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
  .o_smp_ready(o_smp_ready), .o_conv_busy(o_conv_busy), .o_conv_swap(o_conv_swap),
  .o_conv_cfg(o_conv_cfg), .o_por_done(o_por_done), .o_int_clk_mode(o_int_clk_mode),
  .o_cfg(o_cfg)
);

// File: sim/asc_host_model.sv
// Host model driving the serial clock, select and data-in pins
`timescale 1ns/1ns
module asc_host_model (
  // Clock
  input  wire logic i_sys_clk,
  // Serial pins
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_sdi
);
  //--------------------------------------------------------------------------
  // Pin sequencing
  //--------------------------------------------------------------------------
  // Clock low from power-up, select high
  initial begin
    o_sck  = 1'h0;
    o_cs_n = 1'h1;
    o_sdi  = 1'h0;
  end

  // Pins move by NBA on an edge; the synchronisers absorb the phase
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick

  // Frame of nf pulses; select stays low after a full one to watch the flag
  task automatic xfer(input logic [15:0] w, input int nf, output logic [31:0] rd,
                      output bit ok);
    int k;
    rd = 32'h0;
    ok = 1'h0;
    if (o_cs_n) begin
      tick(1);
      o_cs_n <= 1'h0; // Clock is low at this fall
    end
    // Done flag watched as an interrupt before clocking
    for (k = 0; k < 3000 && !ok; k++) begin
      @(posedge i_sys_clk);
      ok = (i_sdo_oe === 1'h1) && (i_sdo === 1'h0);
    end
    for (k = 0; k < nf && ok; k++) begin
      tick(1);
      o_sdi <= (k < 16) ? w[15-k] : ~o_sdi;
      tick(3);
      o_sck <= 1'h1;
      rd[31-k] = i_sdo_oe ? i_sdo : ~i_sdo; // Latched on the rise
      tick(4);
      o_sck <= 1'h0;
    end
    tick(4);
    if (nf < 32) begin
      o_cs_n <= 1'h1;
      o_sdi  <= ~o_sdi; // Released line shows no stale level
    end
    tick(8);
  endtask : xfer

  // Select pulse with the clock pin parked at lvl
  task automatic probe(input logic lvl);
    tick(1);
    o_cs_n <= 1'h1;
    tick(4);
    o_sck <= lvl;
    tick(4);
    o_cs_n <= 1'h0;
    tick(8);
    o_cs_n <= 1'h1;
    tick(4);
    o_sck <= 1'h0;
    tick(4);
  endtask : probe
endmodule : asc_host_model

// File: sim/tb_top.sv
// Self-checking bench of the serial conversion interface
`timescale 1ns/1ns
module tb_top;
  //--------------------------------------------------------------------------
  // Signals, clock and instances
  //--------------------------------------------------------------------------
  localparam int unsigned    POR = 20;
  logic                      i_sys_clk;
  logic                      i_rst;
  logic                      sck;
  logic                      cs_n;
  logic                      sdi;
  logic                      o_sdo;
  logic                      o_sdo_oe;
  logic                      i_smp_valid;
  logic [asc_pkg::SMP_W-1:0] i_smp_data;
  logic                      o_smp_ready;
  logic                      o_conv_busy;
  logic                      o_conv_swap;
  asc_pkg::asc_cfg_t         o_conv_cfg;
  logic                      o_por_done;
  logic                      o_int_clk_mode;
  asc_pkg::asc_cfg_t         o_cfg;
  int                        n_errors = 0;
  int                        num_checks = 0;
  int                        seed;
  logic [2:0]                pre_tab [4] = '{3'h0, 3'h4, 3'h5, 3'h5};
  int                        falls_tab [8] = '{1, 7, 8, 15, 16, 31, 32, 32};

  // Free-running system clock
  initial i_sys_clk = 1'h0;
  always #50 i_sys_clk = ~i_sys_clk;

  asc_serial_if #(.P_POR_CYCLES(POR), .P_BUF_DEPTH(2)) asc_serial_if_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
    .o_smp_ready(o_smp_ready), .o_conv_busy(o_conv_busy), .o_conv_swap(o_conv_swap),
    .o_conv_cfg(o_conv_cfg), .o_por_done(o_por_done), .o_int_clk_mode(o_int_clk_mode),
    .o_cfg(o_cfg)
  );
  asc_host_model asc_host_model_inst (
    .i_sys_clk(i_sys_clk), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .o_sck(sck), .o_cs_n(cs_n),
    .o_sdi(sdi)
  );

  //--------------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Offer a sample and hold it until the buffer takes it
  task automatic push(input logic [29:0] d);
    int k;
    @(posedge i_sys_clk);
    i_smp_valid <= 1'h1;
    i_smp_data  <= d;
    for (k = 0; k < 300; k++) begin
      @(posedge i_sys_clk);
      if (o_smp_ready === 1'h1) break;
    end
    i_smp_valid <= 1'h0;
    if (k == 300) begin
      check("push timeout", 32'h1, 32'h0);
      test_done();
    end
  endtask : push

  // Settings expected after a frame cut at nf falls
  function automatic asc_pkg::asc_cfg_t exp_cfg(asc_pkg::asc_cfg_t c, logic [15:0] w, int nf);
    exp_cfg = c;
    if (w[15:13] == 3'h5 && nf >= 8) begin
      exp_cfg.chan = w[12:8];
    end
    if (w[15:13] == 3'h5 && nf >= 16 && w[7]) begin
      exp_cfg.temp_sensor_select  = w[6];
      exp_cfg.rejection_select_a  = w[5];
      exp_cfg.rejection_select_b  = w[4];
      exp_cfg.speed_double_select = w[3];
    end
  endfunction : exp_cfg

  // Speed mode passes one sample; 1x halves the difference of two
  function automatic logic [29:0] exp_res(asc_pkg::asc_cfg_t c, logic [29:0] a, logic [29:0] b);
    logic signed [30:0] d;
    d = $signed({a[29], a}) - $signed({b[29], b});
    exp_res = (c.speed_double_select && !c.temp_sensor_select) ? a : d[30:1];
  endfunction : exp_res

  //--------------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------------
  initial begin
    logic [31:0]       rd;
    logic [31:0]       mask;
    logic [15:0]       w;
    logic [29:0]       a;
    logic [29:0]       b;
    logic [29:0]       res;
    asc_pkg::asc_cfg_t cfg;
    asc_pkg::asc_cfg_t nxt;
    bit                ok;
    int                nf;
    int                i;
    int                k;
    seed = 32'h071cc792;
    i_rst = 1'h1;
    i_smp_valid = 1'h0;
    i_smp_data = 30'h0;
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    check("oe after reset", {31'h0, o_sdo_oe}, 32'h0);
    // Two samples for the first conversion fill the buffer
    cfg = asc_pkg::CFG_RST;
    a = 30'($random(seed));
    b = 30'($random(seed));
    push(a);
    push(b);
    res = exp_res(cfg, a, b);
    repeat (POR + 8) @(posedge i_sys_clk);
    check("power-on done", {31'h0, o_por_done}, 32'h1);
    for (i = 0; i < 24; i++) begin
      nf = (i < 8) ? falls_tab[i] : 1 + int'($unsigned($random(seed)) % 32);
      w = 16'($random(seed));
      w[15:13] = (i < 8) ? 3'h5 : pre_tab[i % 4];
      w[7] = (i < 8) ? 1'h1 : w[7];
      w[6:3] = (i == 6) ? 4'h1 : (i == 7) ? 4'h9 : w[6:3];
      w[4] = w[4] & ~w[5]; // Reserved rejection code avoided
      nxt = exp_cfg(cfg, w, nf);
      for (k = 0; k < 500 && o_conv_busy !== 1'h0; k++) @(posedge i_sys_clk);
      check("conversion ends", {31'h0, o_conv_busy}, 32'h0);
      if (o_conv_busy !== 1'h0) test_done();
      if (i == 12) begin
        asc_host_model_inst.probe(1'h1);
        check("clock source", {31'h0, o_int_clk_mode}, 32'h1);
        asc_host_model_inst.probe(1'h0);
        check("clock source", {31'h0, o_int_clk_mode}, 32'h0);
      end
      a = 30'($random(seed));
      b = 30'($random(seed));
      push(a);
      if (!(nxt.speed_double_select && !nxt.temp_sensor_select)) begin
        push(b);
        @(posedge i_sys_clk);
        check("buffer full", {31'h0, o_smp_ready}, 32'h0);
      end
      asc_host_model_inst.xfer(w, nf, rd, ok);
      check("flag seen", {31'h0, ok}, 32'h1);
      if (!ok) begin
        test_done();
      end
      mask = 32'hffffffff << (32 - nf);
      check("result word", rd & mask, {2'h0, res} & mask);
      check("stored settings", 32'(o_cfg), 32'(nxt));
      cfg = nxt;
      res = exp_res(nxt, a, b);
    end
    test_done();
  end
endmodule : tb_top
